// *** include/wireless_channel_link_ctrl_regs.vh ***
// register map, field positions, reset values and timing counts of the channel link controller
`ifndef WIRELESS_CHANNEL_LINK_CTRL_REGS_VH
`define WIRELESS_CHANNEL_LINK_CTRL_REGS_VH

// ----------------------------------------
// register index inside a channel window
// ----------------------------------------
`define CH_SHIFT       6
`define REG_CFG        4'h0
`define REG_ID         4'h1
`define REG_PERIOD     4'h2
`define REG_KEY        4'h3
`define REG_TXLO       4'h4
`define REG_TXHI       4'h5
`define REG_STATUS     4'h6
`define REG_RXLO       4'h7
`define REG_RXHI       4'h8

// ----------------------------------------
// field positions
// ----------------------------------------
`define CFG_OPEN       0
`define CFG_ROLE       1
`define CFG_NET        3
`define CFG_MODE       5
`define CFG_ACK        7
`define CFG_WILD       8
`define CFG_RF         16
`define CFG_PROX       23
`define CFG_BINLO      24
`define CFG_BINHI      28
`define ID_DEVNUM      0
`define ID_DEVTYPE     16
`define ID_TXTYPE      24

// ----------------------------------------
// encodings
// ----------------------------------------
`define ROLE_BI_SLAVE  2'h0
`define ROLE_BI_MASTER 2'h1
`define ROLE_SH_SLAVE  2'h2
`define ROLE_RX_SLAVE  2'h3
`define NET_PUBLIC     2'h0
`define RF_MAX         7'h4D
`define BIN_MIN        4'h1
`define BIN_MAX        4'hA

// ----------------------------------------
// reset values
// ----------------------------------------
`define CFG_RST        32'h00000000
`define ID_RST         32'h00000000
`define PERIOD_RST     17'h02000

// ----------------------------------------
// timing: period counted in ticks of TICK_HZ
// ----------------------------------------
`define CLK_HZ         50000000
`define TICK_HZ        32768
`define PERIOD_MIN_US  5200
`define PERIOD_MAX_MS  2000
`define TICK_CYCLES    (`CLK_HZ / `TICK_HZ)
`define PERIOD_MIN     ((`PERIOD_MIN_US * `TICK_HZ + 999999) / 1000000)
`define PERIOD_MAX     ((`PERIOD_MAX_MS * `TICK_HZ) / 1000)

`endif

// *** hdl/wireless_channel_link_ctrl.v ***
// eight-channel slotted radio link controller with an AXI4-Lite register port
//
// Register access over AXI4-Lite and the address map were decided locally.
`timescale 1ns/1ns
`include "wireless_channel_link_ctrl_regs.vh"

module wireless_channel_link_ctrl #(
	parameter TICK_CYCLES = `TICK_CYCLES
) (
	input  wire        aclk,
	input  wire        aresetn,
	input  wire [8:0]  s_axi_awaddr,
	input  wire        s_axi_awvalid,
	output reg         s_axi_awready,
	input  wire [31:0] s_axi_wdata,
	input  wire [3:0]  s_axi_wstrb,
	input  wire        s_axi_wvalid,
	output reg         s_axi_wready,
	output reg  [1:0]  s_axi_bresp,
	output reg         s_axi_bvalid,
	input  wire        s_axi_bready,
	input  wire [8:0]  s_axi_araddr,
	input  wire        s_axi_arvalid,
	output reg         s_axi_arready,
	output reg  [31:0] s_axi_rdata,
	output reg  [1:0]  s_axi_rresp,
	output reg         s_axi_rvalid,
	input  wire        s_axi_rready,
	input  wire        host_port_select,
	input  wire        rf_rx_valid,
	input  wire [2:0]  rf_rx_chan,
	input  wire [31:0] rf_rx_id,
	input  wire [31:0] rf_rx_key,
	input  wire [3:0]  rf_rx_bin,
	input  wire [63:0] rf_rx_data,
	input  wire        rf_done,
	output reg         rf_tx_start,
	output reg         rf_rx_start,
	output reg         rf_reply,
	output reg  [2:0]  rf_chan,
	output reg  [6:0]  rf_freq,
	output reg  [31:0] rf_id,
	output reg  [31:0] rf_key,
	output reg  [63:0] rf_data,
	output reg  [1:0]  rf_mode,
	output reg         single_channel_variant,
	output reg         multi_channel_variant
);

// ----------------------------------------
// state
// ----------------------------------------
localparam ST_IDLE = 1'b0;
localparam ST_BUSY = 1'b1;
localparam [31:0] PER_MIN_W   = `PERIOD_MIN;
localparam [31:0] PER_MAX_W   = `PERIOD_MAX;
localparam [31:0] TICK_LAST_W = TICK_CYCLES - 1;

reg [31:0] cfg_r  [0:7];
reg [31:0] id_r   [0:7];
reg [31:0] key_r  [0:7];
reg [31:0] txlo_r [0:7];
reg [31:0] txhi_r [0:7];
reg [31:0] rxlo_r [0:7];
reg [31:0] rxhi_r [0:7];
reg [16:0] per_r  [0:7];
reg [16:0] cnt_r  [0:7];
reg [3:0]  bin_r  [0:7];
reg [7:0]  due_r;
reg [7:0]  new_r;
reg [7:0]  conn_r;
reg [10:0] tick_cnt_r;
reg        tick_r;
reg        st_r;
reg [2:0]  cur_r;
reg        replied_r;
reg        ps_s1_r;
reg        ps_s2_r;
reg        ps_s3_r;
reg        ps_r;
reg [8:0]  wa_r;
reg [31:0] wd_r;
reg [3:0]  ws_r;
reg        aw_full_r;
reg        w_full_r;

integer i;
wire [2:0]  wch  = wa_r[8:`CH_SHIFT];
wire [3:0]  widx = wa_r[5:2];
wire [2:0]  rch  = s_axi_araddr[8:`CH_SHIFT];
wire [3:0]  ridx = s_axi_araddr[5:2];
wire [31:0] ccfg = cfg_r[cur_r];
wire [1:0]  crole = ccfg[`CFG_ROLE+1:`CFG_ROLE];
wire [7:0]  open_m;
wire        do_wr = aw_full_r & w_full_r & ~s_axi_bvalid;
wire [31:0] cfg_new = merge(cfg_r[wch], wd_r, ws_r);

genvar g;
generate
	for (g = 0; g < 8; g = g + 1) begin : g_open
		assign open_m[g] = cfg_r[g][`CFG_OPEN];
	end
endgenerate

// ----------------------------------------
// functions
// ----------------------------------------
function [31:0] merge;
	input [31:0] o;
	input [31:0] n;
	input [3:0]  s;
	integer k;
	begin
		for (k = 0; k < 4; k = k + 1) begin
			merge[k*8 +: 8] = s[k] ? n[k*8 +: 8] : o[k*8 +: 8];
		end
	end
endfunction

function [16:0] clamp_per;
	input [31:0] v;
	begin
		clamp_per = v < PER_MIN_W ? PER_MIN_W[16:0] : (v > PER_MAX_W ? PER_MAX_W[16:0] : v[16:0]);
	end
endfunction
function [31:0] clamp_rf;
	input [31:0] v;
	begin
		clamp_rf = {v[31:`CFG_RF+7], (v[`CFG_RF+6:`CFG_RF] > `RF_MAX ? `RF_MAX : v[`CFG_RF+6:`CFG_RF]),
			v[`CFG_RF-1:0]};
	end
endfunction

// wildcard bits: 0 transmission type, 1 device type, 2 device number
function id_match;
	input [31:0] want;
	input [31:0] got;
	input [2:0]  wild;
	begin
		id_match = (wild[0] || want[31:24] == got[31:24]) &&
			(wild[1] || want[23:16] == got[23:16]) &&
			(wild[2] || want[15:0] == got[15:0]);
	end
endfunction

function [2:0] pick;
	input [7:0] m;
	integer k;
	begin
		pick = 3'h0;
		for (k = 7; k >= 0; k = k - 1) begin
			pick = m[k] ? k[2:0] : pick;
		end
	end
endfunction

// ----------------------------------------
// peer acceptance for the slot in progress
// ----------------------------------------
wire [2:0] cwild = conn_r[cur_r] ? 3'h0 : ccfg[`CFG_WILD+2:`CFG_WILD];
wire key_ok = ccfg[`CFG_NET+1:`CFG_NET] == `NET_PUBLIC || rf_rx_key == key_r[cur_r];
wire bin_ok = ~ccfg[`CFG_PROX] ||
	(rf_rx_bin >= `BIN_MIN && rf_rx_bin <= `BIN_MAX &&
	rf_rx_bin >= ccfg[`CFG_BINLO+3:`CFG_BINLO] &&
	rf_rx_bin <= ccfg[`CFG_BINHI+3:`CFG_BINHI]);
wire rx_hit = st_r == ST_BUSY && rf_rx_valid && rf_rx_chan == cur_r;
wire accept = rx_hit && key_ok && bin_ok && id_match(id_r[cur_r], rf_rx_id, cwild);

// ----------------------------------------
// strap capture and timebase
// ----------------------------------------
always @(posedge aclk) begin
	if (!aresetn) begin
		ps_s1_r <= 1'b0;
		ps_s2_r <= 1'b0;
		ps_s3_r <= 1'b0;
		ps_r <= 1'b0;
		tick_cnt_r <= 11'h000;
		tick_r <= 1'b0;
		single_channel_variant <= 1'b0;
		multi_channel_variant <= 1'b0;
	end else begin
		ps_s1_r <= host_port_select;
		ps_s2_r <= ps_s1_r;
		ps_s3_r <= ps_s2_r;
		ps_r <= ps_s2_r == ps_s3_r ? ps_s3_r : ps_r;
		single_channel_variant <= 1'b0;
		multi_channel_variant <= 1'b1;
		tick_r <= tick_cnt_r == TICK_LAST_W[10:0];
		tick_cnt_r <= tick_cnt_r == TICK_LAST_W[10:0] ? 11'h000 : tick_cnt_r + 11'h001;
	end
end

// ----------------------------------------
// register port, channel timers and slot engine
// ----------------------------------------
always @(posedge aclk) begin
	if (!aresetn) begin
		s_axi_awready <= 1'b0;
		s_axi_wready <= 1'b0;
		s_axi_bvalid <= 1'b0;
		s_axi_bresp <= 2'h0;
		s_axi_arready <= 1'b0;
		s_axi_rvalid <= 1'b0;
		s_axi_rresp <= 2'h0;
		s_axi_rdata <= 32'h00000000;
		aw_full_r <= 1'b0;
		w_full_r <= 1'b0;
		wa_r <= 9'h000;
		wd_r <= 32'h00000000;
		ws_r <= 4'h0;
		due_r <= 8'h00;
		new_r <= 8'h00;
		conn_r <= 8'h00;
		st_r <= ST_IDLE;
		cur_r <= 3'h0;
		replied_r <= 1'b0;
		rf_tx_start <= 1'b0;
		rf_rx_start <= 1'b0;
		rf_reply <= 1'b0;
		rf_chan <= 3'h0;
		rf_freq <= 7'h00;
		rf_id <= 32'h00000000;
		rf_key <= 32'h00000000;
		rf_data <= 64'h0000000000000000;
		rf_mode <= 2'h0;
		for (i = 0; i < 8; i = i + 1) begin
			cfg_r[i] <= `CFG_RST;
			id_r[i] <= `ID_RST;
			key_r[i] <= 32'h00000000;
			txlo_r[i] <= 32'h00000000;
			txhi_r[i] <= 32'h00000000;
			rxlo_r[i] <= 32'h00000000;
			rxhi_r[i] <= 32'h00000000;
			per_r[i] <= `PERIOD_RST;
			cnt_r[i] <= `PERIOD_RST;
			bin_r[i] <= 4'h0;
		end
	end else begin
		rf_tx_start <= 1'b0;
		rf_rx_start <= 1'b0;
		// per-channel slot timers, counting only while open
		for (i = 0; i < 8; i = i + 1) begin
			if (!open_m[i]) begin
				due_r[i] <= 1'b0;
			end else if (tick_r) begin
				if (cnt_r[i] <= 17'h00001) begin
					cnt_r[i] <= per_r[i];
					due_r[i] <= 1'b1;
				end else begin
					cnt_r[i] <= cnt_r[i] - 17'h00001;
				end
			end
		end
		// slot engine: one channel holds the link at a time
		case (st_r)
		ST_IDLE: begin
			if (|(due_r & open_m)) begin
				cur_r <= pick(due_r & open_m);
				due_r[pick(due_r & open_m)] <= 1'b0;
				rf_chan <= pick(due_r & open_m);
				rf_freq <= cfg_r[pick(due_r & open_m)][`CFG_RF+6:`CFG_RF];
				rf_id <= id_r[pick(due_r & open_m)];
				rf_key <= key_r[pick(due_r & open_m)];
				rf_mode <= cfg_r[pick(due_r & open_m)][`CFG_MODE+1:`CFG_MODE];
				rf_reply <= 1'b0;
				replied_r <= 1'b0;
				st_r <= ST_BUSY;
				if (cfg_r[pick(due_r & open_m)][`CFG_ROLE+1:`CFG_ROLE] == `ROLE_BI_MASTER) begin
					rf_tx_start <= 1'b1;
					rf_data <= {txhi_r[pick(due_r & open_m)], txlo_r[pick(due_r & open_m)]};
					new_r[pick(due_r & open_m)] <= 1'b0;
				end else begin
					rf_rx_start <= 1'b1;
				end
			end
		end
		ST_BUSY: begin
			if (crole == `ROLE_BI_MASTER) begin
				if (rx_hit && key_ok && id_match(id_r[cur_r], rf_rx_id, 3'h0)) begin
					rxlo_r[cur_r] <= rf_rx_data[31:0];
					rxhi_r[cur_r] <= rf_rx_data[63:32];
				end
			end else if (accept) begin
				conn_r[cur_r] <= 1'b1;
				id_r[cur_r] <= rf_rx_id;
				bin_r[cur_r] <= rf_rx_bin;
				rxlo_r[cur_r] <= rf_rx_data[31:0];
				rxhi_r[cur_r] <= rf_rx_data[63:32];
				cnt_r[cur_r] <= per_r[cur_r];
				if (crole != `ROLE_RX_SLAVE && !replied_r && (ccfg[`CFG_ACK] || new_r[cur_r])) begin
					rf_tx_start <= 1'b1;
					rf_reply <= 1'b1;
					rf_id <= rf_rx_id;
					rf_data <= {txhi_r[cur_r], txlo_r[cur_r]};
					new_r[cur_r] <= 1'b0;
					replied_r <= 1'b1;
				end
			end
			if (rf_done) begin
				st_r <= ST_IDLE;
			end
		end
		default: st_r <= ST_IDLE;
		endcase
		// AXI4-Lite write: address and data in either order
		if (s_axi_awvalid && s_axi_awready) begin
			wa_r <= s_axi_awaddr;
			aw_full_r <= 1'b1;
			s_axi_awready <= 1'b0;
		end else if (!aw_full_r && !s_axi_bvalid) begin
			s_axi_awready <= 1'b1;
		end
		if (s_axi_wvalid && s_axi_wready) begin
			wd_r <= s_axi_wdata;
			ws_r <= s_axi_wstrb;
			w_full_r <= 1'b1;
			s_axi_wready <= 1'b0;
		end else if (!w_full_r && !s_axi_bvalid) begin
			s_axi_wready <= 1'b1;
		end
		if (do_wr) begin
			aw_full_r <= 1'b0;
			w_full_r <= 1'b0;
			s_axi_bvalid <= 1'b1;
			s_axi_bresp <= widx > `REG_RXHI ? 2'h2 : 2'h0;
			case (widx)
			`REG_CFG: begin
				cfg_r[wch] <= clamp_rf(cfg_new);
				if (cfg_new[`CFG_OPEN] && !cfg_r[wch][`CFG_OPEN]) begin
					cnt_r[wch] <= 17'h00001;
					conn_r[wch] <= cfg_new[`CFG_ROLE+1:`CFG_ROLE] == `ROLE_BI_MASTER;
				end
			end
			`REG_ID: id_r[wch] <= merge(id_r[wch], wd_r, ws_r);
			`REG_PERIOD: per_r[wch] <= clamp_per(merge({15'h0000, per_r[wch]}, wd_r, ws_r));
			`REG_KEY: key_r[wch] <= merge(key_r[wch], wd_r, ws_r);
			`REG_TXLO: txlo_r[wch] <= merge(txlo_r[wch], wd_r, ws_r);
			`REG_TXHI: begin
				txhi_r[wch] <= merge(txhi_r[wch], wd_r, ws_r);
				new_r[wch] <= 1'b1;
			end
			default: ;
			endcase
		end
		if (s_axi_bvalid && s_axi_bready) begin
			s_axi_bvalid <= 1'b0;
			s_axi_awready <= 1'b1;
			s_axi_wready <= 1'b1;
		end
		// AXI4-Lite read
		if (s_axi_arvalid && s_axi_arready) begin
			s_axi_arready <= 1'b0;
			s_axi_rvalid <= 1'b1;
			s_axi_rresp <= ridx > `REG_RXHI ? 2'h2 : 2'h0;
			case (ridx)
			`REG_CFG: s_axi_rdata <= cfg_r[rch];
			`REG_ID: s_axi_rdata <= id_r[rch];
			`REG_PERIOD: s_axi_rdata <= {15'h0000, per_r[rch]};
			`REG_KEY: s_axi_rdata <= key_r[rch];
			`REG_TXLO: s_axi_rdata <= txlo_r[rch];
			`REG_TXHI: s_axi_rdata <= txhi_r[rch];
			`REG_STATUS: s_axi_rdata <= {ps_r, 23'h000000, bin_r[rch], due_r[rch], new_r[rch],
				conn_r[rch], open_m[rch]};
			`REG_RXLO: s_axi_rdata <= rxlo_r[rch];
			`REG_RXHI: s_axi_rdata <= rxhi_r[rch];
			default: s_axi_rdata <= 32'h00000000;
			endcase
		end else if (s_axi_rvalid && s_axi_rready) begin
			s_axi_rvalid <= 1'b0;
			s_axi_arready <= 1'b1;
		end else if (!s_axi_rvalid) begin
			s_axi_arready <= 1'b1;
		end
	end
end

endmodule

// *** testbench/link_chk_sva.sv ***
// assertions on the ports of the channel link controller
`timescale 1ns/1ns
module link_chk #(
	parameter TICK_CYCLES = 4
) (
	input wire        aclk,
	input wire        aresetn,
	input wire        s_axi_awvalid,
	input wire        s_axi_awready,
	input wire        s_axi_wvalid,
	input wire        s_axi_wready,
	input wire [1:0]  s_axi_bresp,
	input wire        s_axi_bvalid,
	input wire        s_axi_bready,
	input wire        s_axi_arvalid,
	input wire        s_axi_arready,
	input wire [31:0] s_axi_rdata,
	input wire        s_axi_rvalid,
	input wire        s_axi_rready,
	input wire        rf_rx_valid,
	input wire        rf_done,
	input wire        rf_tx_start,
	input wire        rf_rx_start,
	input wire        rf_reply,
	input wire [2:0]  rf_chan,
	input wire [6:0]  rf_freq,
	input wire [31:0] rf_id,
	input wire        single_channel_variant,
	input wire        multi_channel_variant
);
	wire slot_go;
	reg  busy_r;
	assign slot_go = rf_rx_start | (rf_tx_start & ~rf_reply);
	// link held from a slot start until the radio reports done
	always @(posedge aclk) begin
		if (!aresetn)
			busy_r <= 1'b0;
		else if (slot_go)
			busy_r <= 1'b1;
		else if (rf_done)
			busy_r <= 1'b0;
	end
	default clocking @(posedge aclk); endclocking
	default disable iff (!aresetn);
	one_start_a: assert property (!(rf_tx_start && rf_rx_start))
		else $error("both start pulses at once");
	start_pulse_a: assert property (slot_go |=> !slot_go)
		else $error("slot start longer than one cycle");
	link_free_a: assert property (slot_go |-> !busy_r)
		else $error("slot started before link freed");
	freq_range_a: assert property (slot_go |-> rf_freq <= 7'h4D)
		else $error("frequency above range");
	field_hold_a: assert property (!(rf_tx_start || rf_rx_start) |-> $stable({rf_chan, rf_freq, rf_id}))
		else $error("slot fields moved between starts");
	reply_cause_a: assert property (rf_tx_start && rf_reply |-> $past(rf_rx_valid))
		else $error("reply without accepted packet");
	write_resp_a: assert property (s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready |-> ##2 s_axi_bvalid)
		else $error("write response late");
	resp_hold_a: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp))
		else $error("write response dropped");
	read_resp_a: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid && !s_axi_arready)
		else $error("read data late");
	rdata_hold_a: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
		else $error("read data dropped");
	variant_a: assert property ($past(aresetn) |-> multi_channel_variant && !single_channel_variant)
		else $error("wrong variant flags");
	cover property (rf_tx_start && !rf_reply);
	cover property (rf_tx_start && rf_reply);
	cover property (s_axi_bvalid && s_axi_bresp == 2'h2);
endmodule
bind wireless_channel_link_ctrl link_chk #(.TICK_CYCLES(TICK_CYCLES)) u_link_chk (.*);

// *** testbench/peer_radio_model.sv ***
// behavioural radio peer answering the controller's slots
`timescale 1ns/1ns
module peer_radio_model (
	input wire        aclk,
	input wire        rf_tx_start,
	input wire        rf_rx_start,
	input wire        rf_reply,
	input wire [2:0]  rf_chan,
	input wire [6:0]  rf_freq,
	input wire [31:0] rf_id,
	input wire [63:0] rf_data,
	output reg        rf_rx_valid,
	output reg [2:0]  rf_rx_chan,
	output reg [31:0] rf_rx_id,
	output reg [31:0] rf_rx_key,
	output reg [3:0]  rf_rx_bin,
	output reg [63:0] rf_rx_data,
	output reg        rf_done
);
	reg [31:0] peer_id [0:7];
	reg [31:0] peer_key [0:7];
	reg [3:0]  peer_bin [0:7];
	reg [63:0] peer_data [0:7];
	reg [31:0] tx_id [0:7];
	reg [63:0] tx_data [0:7];
	reg [6:0]  tx_freq [0:7];
	int        tx_cnt [0:7] = '{default: 0};
	int        reply_cnt [0:7] = '{default: 0};
	reg [2:0]  ch;
	reg        sl;
	int        lat;
	always @(posedge aclk) begin
		if (rf_tx_start && rf_reply)
			reply_cnt[rf_chan] <= reply_cnt[rf_chan] + 1;
		if (rf_tx_start && !rf_reply) begin
			tx_cnt[rf_chan] <= tx_cnt[rf_chan] + 1;
			tx_id[rf_chan] <= rf_id;
			tx_data[rf_chan] <= rf_data;
			tx_freq[rf_chan] <= rf_freq;
		end
	end
	initial begin
		rf_rx_valid = 1'b0;
		rf_done = 1'b0;
		{rf_rx_chan, rf_rx_id, rf_rx_key, rf_rx_bin, rf_rx_data} = '0;
		lat = 1;
		forever begin
			@(posedge aclk);
			if (rf_rx_start || (rf_tx_start && !rf_reply)) begin
				ch = rf_chan;
				sl = rf_rx_start;
				// alternate prompt and slow answers
				lat = 6 - lat;
				repeat (lat) @(posedge aclk);
				if (sl) begin
					rf_rx_valid <= 1'b1;
					rf_rx_chan <= ch;
					rf_rx_id <= peer_id[ch];
					rf_rx_key <= peer_key[ch];
					rf_rx_bin <= peer_bin[ch];
					rf_rx_data <= peer_data[ch];
					@(posedge aclk);
					rf_rx_valid <= 1'b0;
					{rf_rx_id, rf_rx_key, rf_rx_data} <= ~{rf_rx_id, rf_rx_key, rf_rx_data};
				end
				repeat (2) @(posedge aclk);
				rf_done <= 1'b1;
				@(posedge aclk);
				rf_done <= 1'b0;
			end
		end
	end
endmodule

// *** testbench/wireless_channel_link_ctrl_tb.sv ***
// self-checking bench for the channel link controller
`timescale 1ns/1ns
`include "wireless_channel_link_ctrl_regs.vh"
`define CHK(g, e) begin n_checks++; if ((g) !== (e)) begin err_count++; \
	$display("mismatch t=%0t got=%0h exp=%0h", $time, g, e); end end
module wireless_channel_link_ctrl_tb;
	reg         aclk = 1'b0;
	reg         aresetn = 1'b0;
	reg  [8:0]  s_axi_awaddr = 9'h000;
	reg         s_axi_awvalid = 1'b0;
	reg  [31:0] s_axi_wdata = 32'h0;
	reg  [3:0]  s_axi_wstrb = 4'hF;
	reg         s_axi_wvalid = 1'b0;
	reg         s_axi_bready = 1'b0;
	reg  [8:0]  s_axi_araddr = 9'h000;
	reg         s_axi_arvalid = 1'b0;
	reg         s_axi_rready = 1'b0;
	reg         host_port_select = 1'b1;
	wire        s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
	wire [1:0]  s_axi_bresp, s_axi_rresp, rf_mode;
	wire [31:0] s_axi_rdata, rf_rx_id, rf_rx_key, rf_id, rf_key;
	wire        rf_rx_valid, rf_done, rf_tx_start, rf_rx_start, rf_reply;
	wire [2:0]  rf_rx_chan, rf_chan;
	wire [3:0]  rf_rx_bin;
	wire [63:0] rf_rx_data, rf_data;
	wire [6:0]  rf_freq;
	wire        single_channel_variant, multi_channel_variant;
	int         err_count = 0;
	int         n_checks = 0;
	reg  [31:0] d, id, sid [0:7];
	reg  [63:0] tx;
	reg  [1:0]  r;
	reg  [6:0]  rf;
	reg         econ [0:7], erep [0:7];
	wireless_channel_link_ctrl #(.TICK_CYCLES(4)) u_wireless_channel_link_ctrl (.*);
	peer_radio_model u_peer (.*);
	always #10 aclk = ~aclk;
	function [8:0] ad(input [2:0] c, input [3:0] x);
		ad = {c, x, 2'b00};
	endfunction
	task automatic wr(input [8:0] a, input [31:0] v, output [1:0] rs);
		bit got = 0;
		@(posedge aclk);
		s_axi_awaddr <= a;
		s_axi_wdata <= v;
		s_axi_awvalid <= 1'b1;
		s_axi_wvalid <= 1'b1;
		s_axi_bready <= 1'b1;
		for (int i = 0; i < 100 && !got; i++) begin
			@(posedge aclk);
			if (s_axi_awready) s_axi_awvalid <= 1'b0;
			if (s_axi_wready) s_axi_wvalid <= 1'b0;
			if (s_axi_bvalid) begin
				rs = s_axi_bresp;
				s_axi_bready <= 1'b0;
				got = 1;
			end
		end
		if (!got) err_count++;
	endtask
	task automatic rd(input [8:0] a, output [31:0] v, output [1:0] rs);
		bit got = 0;
		@(posedge aclk);
		s_axi_araddr <= a;
		s_axi_arvalid <= 1'b1;
		s_axi_rready <= 1'b1;
		for (int i = 0; i < 100 && !got; i++) begin
			@(posedge aclk);
			if (s_axi_arready) s_axi_arvalid <= 1'b0;
			if (s_axi_rvalid) begin
				v = s_axi_rdata;
				rs = s_axi_rresp;
				s_axi_rready <= 1'b0;
				got = 1;
			end
		end
		if (!got) err_count++;
	endtask
	task automatic chk_rd(input [8:0] a, input [31:0] e);
		rd(a, d, r);
		`CHK(d, e)
	endtask
	task automatic wait_tx(input int n);
		for (int i = 0; i < 3000 && u_peer.tx_cnt[0] < n; i++) @(posedge aclk);
		if (u_peer.tx_cnt[0] < n) err_count++;
	endtask
	// slave on channel c, proximity bins 1..2, devnum wildcarded
	task automatic open_slave(input [2:0] c, input [1:0] role, input [1:0] net, input kok, input prox,
		input [3:0] bin);
		reg [31:0] key;
		key = $urandom;
		sid[c] = $urandom;
		u_peer.peer_id[c] = sid[c];
		u_peer.peer_key[c] = kok ? key : ~key;
		u_peer.peer_bin[c] = bin;
		u_peer.peer_data[c] = {$urandom, $urandom};
		econ[c] = (net == 2'h0 || kok) && (!prox || bin <= 4'h2);
		erep[c] = econ[c] && role != 2'h3;
		wr(ad(c, `REG_ID), {sid[c][31:16], 16'h0000}, r);
		wr(ad(c, `REG_KEY), key, r);
		wr(ad(c, `REG_PERIOD), 32'h0, r);
		wr(ad(c, `REG_CFG), {8'h21, prox, 4'h0, c, 5'h00, 4'h9, 2'h0, net, role, 1'b1}, r);
	endtask
	task stop_test;
		$display("checks=%0d mismatches=%0d", n_checks, err_count);
		if (err_count == 0 && n_checks > 0)
			$display("SIMULATION PASSED");
		else
			$display("SIMULATION FAILED");
		$finish;
	endtask
	initial begin
		repeat (40000) @(posedge aclk);
		err_count++;
		stop_test;
	end
	initial begin
		void'($urandom(32'h8146));
		repeat (6) @(posedge aclk);
		aresetn <= 1'b1;
		@(posedge aclk);
		chk_rd(ad(3'h0, `REG_CFG), `CFG_RST);
		chk_rd(ad(3'h5, `REG_ID), `ID_RST);
		chk_rd(ad(3'h2, `REG_PERIOD), 32'h00002000);
		rd(ad(3'h0, `REG_STATUS), d, r);
		`CHK({d[31], d[1:0]}, 3'h4)
		host_port_select <= 1'b0;
		wr(9'h024, 32'hFFFFFFFF, r);
		`CHK(r, 2'h2)
		rd(9'h1E4, d, r);
		`CHK({r, d}, 34'h200000000)
		wr(ad(3'h7, `REG_PERIOD), 32'h0001FFFF, r);
		chk_rd(ad(3'h7, `REG_PERIOD), 32'h00010000);
		wr(ad(3'h7, `REG_CFG), 32'h00640000, r);
		chk_rd(ad(3'h7, `REG_CFG), 32'h004D0000);
		chk_rd(ad(3'h6, `REG_CFG), `CFG_RST);
		id = $urandom;
		tx = {$urandom, $urandom};
		rf = $urandom % 78;
		wr(ad(3'h0, `REG_ID), id, r);
		wr(ad(3'h0, `REG_TXLO), tx[31:0], r);
		wr(ad(3'h0, `REG_TXHI), tx[63:32], r);
		wr(ad(3'h0, `REG_PERIOD), 32'h0, r);
		wr(ad(3'h0, `REG_KEY), ~id, r);
		chk_rd(ad(3'h0, `REG_PERIOD), 32'h000000AB);
		wr(ad(3'h0, `REG_CFG), {9'h000, rf, 16'h0023}, r);
		wait_tx(1);
		`CHK(rf_mode, 2'h1)
		`CHK(rf_key, ~id)
		`CHK(u_peer.tx_id[0], id)
		`CHK(u_peer.tx_data[0], tx)
		`CHK(u_peer.tx_freq[0], rf)
		wait_tx(2);
		`CHK(u_peer.tx_data[0], tx)
		tx[63:32] = $urandom;
		wr(ad(3'h0, `REG_TXHI), tx[63:32], r);
		wait_tx(u_peer.tx_cnt[0] + 1);
		`CHK(u_peer.tx_data[0], tx)
		open_slave(3'h1, 2'h0, 2'h0, 1'b0, 1'b0, 4'h7);
		open_slave(3'h2, 2'h2, 2'h1, 1'b1, 1'b1, 4'h2);
		open_slave(3'h3, 2'h3, 2'h2, 1'b1, 1'b0, 4'h4);
		open_slave(3'h4, 2'h0, 2'h1, 1'b0, 1'b0, 4'h1);
		open_slave(3'h5, 2'h0, 2'h0, 1'b1, 1'b1, 4'h5);
		// over three minimum periods of 171 ticks (2500 cycles, 625 ticks)
		repeat (2500) @(posedge aclk);
		for (int c = 1; c < 6; c++) begin
			rd(ad(c[2:0], `REG_STATUS), d, r);
			`CHK(d[1], econ[c])
			`CHK(d[31], 1'b0)
			`CHK(u_peer.reply_cnt[c] > 0, erep[c])
			chk_rd(ad(c[2:0], `REG_ID), econ[c] ? sid[c] : {sid[c][31:16], 16'h0000});
			if (econ[c]) begin
				chk_rd(ad(c[2:0], `REG_RXLO), u_peer.peer_data[c][31:0]);
				chk_rd(ad(c[2:0], `REG_RXHI), u_peer.peer_data[c][63:32]);
			end
		end
		stop_test;
	end
endmodule
